// ===== logic/pxs_regs.vh
// Constants of the parallel expansion site port: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef PXS_REGS_VH
`define PXS_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word addresses on the control port)
// ----------------------------------------------------------------
`define PXS_OFS_RESET_CTRL   4'h0
`define PXS_OFS_IRQ0_ROUTE   4'h1
`define PXS_OFS_IRQ1_ROUTE   4'h2
`define PXS_OFS_IRQ2_ROUTE   4'h3
`define PXS_OFS_IRQ3_ROUTE   4'h4
`define PXS_OFS_NMI_ROUTE    4'h5
`define PXS_OFS_TIO_CONFIG   4'h6
`define PXS_OFS_IRQ_STATUS   4'h7
`define PXS_OFS_IRQ_MASK     4'h8
`define PXS_OFS_BUS_STATUS   4'h9

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PXS_BIT_MOD_RESET    0
`define PXS_BIT_TIO0_GPIO    0
`define PXS_BIT_TIO0_DIR     1
`define PXS_BIT_TIO0_DATA    2
`define PXS_RST_RESET_CTRL   1'h0
`define PXS_RST_ROUTE        2'h0
`define PXS_RST_TIO_CONFIG   3'h0
`define PXS_RST_IRQ_MASK     4'h0
`define PXS_ST_BIT_DONE      0
`define PXS_ST_BIT_TIMEOUT   1
`define PXS_ST_BIT_ALT_DONE  2
`define PXS_ST_BIT_IRQ_FALL  3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PXS_CLK_PERIOD_PS    4000
`define PXS_READY_LIMIT_NS   2000
`define PXS_READY_LIMIT_CYC  ((`PXS_READY_LIMIT_NS * 1000) / `PXS_CLK_PERIOD_PS)

`endif

// ===== logic/pxs_irq_edge.v
// Falling-edge detector for one active-low module interrupt input.
// Assumes the input is synchronous to the clock in name only and so
// passes it through two flip-flops before looking at it.
`timescale 1ns/1ps

module pxs_irq_edge
(
	input  wire core_clk_in,
	input  wire rst_in,
	input  wire irq_n_in,
	output reg  fall_out,
	output wire level_n_out
);

	reg meta_r;
	reg sync_r;
	reg last_r;

	assign level_n_out = sync_r;

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			meta_r   <= 1'b1;
			sync_r   <= 1'b1;
			last_r   <= 1'b1;
			fall_out <= 1'b0;
		end
		else
		begin
			meta_r   <= irq_n_in;
			sync_r   <= meta_r;
			last_r   <= sync_r;
			fall_out <= last_r & ~sync_r;
		end
	end

endmodule // pxs_irq_edge

// ===== logic/pxs_site_port.v
// Parallel expansion site port: DSP I/O window onto the daughter module,
// module reset, interrupt routing and the first timer/IO pin.
// Assumes a DSP-side I/O request port and a simple register port, all
// synchronous to core_clk_in.
//
// What this block does
// - The site is a 64K by 16 window in DSP I/O space with sixteen address lines and a 16-bit data bus.
// - DSP I/O accesses go to the site only while the space select flag is low.
// - With the flag high, accesses go to the 8-bit parallel area of the serial site instead.
// - Only full 16-bit transfers are made at the site, with no width or byte select signals.
// - An active-low strobe marks each access to the site.
// - An active-low write enable gives the direction during a strobed transfer.
// - One common strobe qualifies the cycle and a separate write level gives its direction.
// - A transfer stays open until ready is seen low; if READY_LIMIT cycles pass first, it ends with all-ones data.
// - An active-low module reset output follows a software bit in the reset control register.
// - Two active-low module interrupts route to any of four DSP interrupt inputs or to NMI.
// - A routed DSP interrupt is raised on the falling edge of a module interrupt, not its level.
// - The first timer/IO pin is either the DSP timer output or a general I/O pin by configuration.
`timescale 1ns/1ps
`include "pxs_regs.vh"

module pxs_site_port
#(
	parameter READY_LIMIT = `PXS_READY_LIMIT_CYC
)
(
	input  wire        core_clk_in,
	input  wire        rst_in,
	// DSP I/O request side
	input  wire        dsp_io_req_in,
	input  wire        dsp_io_write_in,
	input  wire [15:0] dsp_io_addr_in,
	input  wire [15:0] dsp_io_wdata_in,
	input  wire        space_select_flag_in,
	output wire        dsp_io_ready_out,
	output reg         dsp_io_done_out,
	output reg  [15:0] dsp_io_rdata_out,
	// Parallel expansion site pins
	output reg  [15:0] expansion_address_lines_out,
	output reg  [15:0] expansion_data_lines_out,
	output reg         expansion_data_oe_out,
	input  wire [15:0] expansion_data_lines_in,
	output reg         expansion_strobe_n_out,
	output reg         expansion_write_enable_n_out,
	input  wire        expansion_ready_n_in,
	output wire        expansion_module_reset_n_out,
	input  wire        expansion_irq0_n_in,
	input  wire        expansion_irq1_n_in,
	// Serial site 8-bit parallel area
	output reg         alt_area_req_out,
	output reg         alt_area_write_out,
	output reg  [15:0] alt_area_addr_out,
	output reg  [7:0]  alt_area_wdata_out,
	input  wire        alt_area_done_in,
	input  wire [7:0]  alt_area_rdata_in,
	// DSP interrupt lines, one-cycle pulses
	output reg  [3:0]  dsp_ext_irq_inputs_out,
	output reg         dsp_nmi_out,
	// First timer/IO pin
	input  wire        dsp_timer_out_in,
	input  wire        timer_io_pin0_in,
	output reg         timer_io_pin0_out,
	output reg         timer_io_pin0_oe_out,
	// Register port
	input  wire [3:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_write_in,
	input  wire        reg_read_in,
	output reg  [15:0] reg_rdata_out,
	output wire        irq_out
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam ST_IDLE  = 2'h0;
	localparam ST_WAIT  = 2'h1;
	localparam ST_ALT   = 2'h2;
	localparam ST_END   = 2'h3;

	reg [1:0]  state_r;
	reg [15:0] wait_cnt_r;
	reg        rdy_meta_r;
	reg        rdy_sync_r;
	reg        mod_reset_r;
	reg [1:0]  route_r [0:4];
	reg [2:0]  tio_cfg_r;
	reg [3:0]  irq_status_r;
	reg [3:0]  irq_mask_r;
	reg [3:0]  irq_status_nxt;

	wire [1:0] fall;
	wire [1:0] irq_level_n;
	reg  [4:0] route_hit;
	reg        ev_done;
	reg        ev_timeout;
	reg        ev_alt;

	// ----------------------------------------------------------------
	// Interrupt input synchronisers and edge detectors
	// ----------------------------------------------------------------
	pxs_irq_edge u_edge0
	(
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.irq_n_in    (expansion_irq0_n_in),
		.fall_out    (fall[0]),
		.level_n_out (irq_level_n[0])
	);

	pxs_irq_edge u_edge1
	(
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.irq_n_in    (expansion_irq1_n_in),
		.fall_out    (fall[1]),
		.level_n_out (irq_level_n[1])
	);

	// ----------------------------------------------------------------
	// Interrupt routing
	// ----------------------------------------------------------------
	// Route code 0 takes module interrupt 0, code 1 takes module
	// interrupt 1, codes 2 and 3 leave the DSP line unused.
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1)
		begin : g_route
			always @*
			begin
				route_hit[gi] = ((route_r[gi] == 2'h0) & fall[0]) |
				                ((route_r[gi] == 2'h1) & fall[1]);
			end
		end
	endgenerate

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			dsp_ext_irq_inputs_out <= 4'h0;
			dsp_nmi_out            <= 1'b0;
		end
		else
		begin
			dsp_ext_irq_inputs_out <= route_hit[3:0];
			dsp_nmi_out            <= route_hit[4];
		end
	end

	// ----------------------------------------------------------------
	// Ready synchroniser
	// ----------------------------------------------------------------
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			rdy_meta_r <= 1'b1;
			rdy_sync_r <= 1'b1;
		end
		else
		begin
			rdy_meta_r <= expansion_ready_n_in;
			rdy_sync_r <= rdy_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	assign dsp_io_ready_out = (state_r == ST_IDLE);

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_r                      <= ST_IDLE;
			wait_cnt_r                   <= 16'h0000;
			expansion_address_lines_out  <= 16'h0000;
			expansion_data_lines_out     <= 16'h0000;
			expansion_data_oe_out        <= 1'b0;
			expansion_strobe_n_out       <= 1'b1;
			expansion_write_enable_n_out <= 1'b1;
			alt_area_req_out             <= 1'b0;
			alt_area_write_out           <= 1'b0;
			alt_area_addr_out            <= 16'h0000;
			alt_area_wdata_out           <= 8'h00;
			dsp_io_done_out              <= 1'b0;
			dsp_io_rdata_out             <= 16'h0000;
			ev_done                      <= 1'b0;
			ev_timeout                   <= 1'b0;
			ev_alt                       <= 1'b0;
		end
		else
		begin
			dsp_io_done_out <= 1'b0;
			ev_done         <= 1'b0;
			ev_timeout      <= 1'b0;
			ev_alt          <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (dsp_io_req_in && !space_select_flag_in)
					begin
						expansion_address_lines_out  <= dsp_io_addr_in;
						expansion_data_lines_out     <= dsp_io_wdata_in;
						expansion_data_oe_out        <= dsp_io_write_in;
						expansion_strobe_n_out       <= 1'b0;
						expansion_write_enable_n_out <= ~dsp_io_write_in;
						wait_cnt_r                   <= 16'h0000;
						state_r                      <= ST_WAIT;
					end
					else if (dsp_io_req_in)
					begin
						alt_area_req_out   <= 1'b1;
						alt_area_write_out <= dsp_io_write_in;
						alt_area_addr_out  <= dsp_io_addr_in;
						alt_area_wdata_out <= dsp_io_wdata_in[7:0];
						state_r            <= ST_ALT;
					end
				end
				ST_WAIT:
				begin
					if (!rdy_sync_r)
					begin
						dsp_io_rdata_out <= expansion_data_lines_in;
						dsp_io_done_out  <= 1'b1;
						ev_done          <= 1'b1;
						state_r          <= ST_END;
					end
					else if (wait_cnt_r == READY_LIMIT[15:0] - 16'h0001)
					begin
						// A missing module would hang the DSP; give up with
						// all-ones data and flag it.
						dsp_io_rdata_out <= 16'hFFFF;
						dsp_io_done_out  <= 1'b1;
						ev_timeout       <= 1'b1;
						state_r          <= ST_END;
					end
					else
					begin
						wait_cnt_r <= wait_cnt_r + 16'h0001;
					end
					if (!rdy_sync_r || wait_cnt_r == READY_LIMIT[15:0] - 16'h0001)
					begin
						expansion_strobe_n_out       <= 1'b1;
						expansion_write_enable_n_out <= 1'b1;
					end
				end
				ST_ALT:
				begin
					if (alt_area_done_in)
					begin
						alt_area_req_out <= 1'b0;
						dsp_io_rdata_out <= {8'h00, alt_area_rdata_in};
						dsp_io_done_out  <= 1'b1;
						ev_alt           <= 1'b1;
						state_r          <= ST_IDLE;
					end
				end
				ST_END:
				begin
					// Data held one cycle past the strobe's rise, then released.
					expansion_data_oe_out <= 1'b0;
					if (rdy_sync_r)
					begin
						state_r <= ST_IDLE;
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Timer/IO pin 0
	// ----------------------------------------------------------------
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			timer_io_pin0_out    <= 1'b0;
			timer_io_pin0_oe_out <= 1'b0;
		end
		else if (tio_cfg_r[`PXS_BIT_TIO0_GPIO])
		begin
			timer_io_pin0_out    <= tio_cfg_r[`PXS_BIT_TIO0_DATA];
			timer_io_pin0_oe_out <= tio_cfg_r[`PXS_BIT_TIO0_DIR];
		end
		else
		begin
			timer_io_pin0_out    <= dsp_timer_out_in;
			timer_io_pin0_oe_out <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	assign expansion_module_reset_n_out = ~mod_reset_r;
	assign irq_out = |(irq_status_r & irq_mask_r);

	always @*
	begin
		irq_status_nxt = irq_status_r;
		if (reg_read_in && reg_addr_in == `PXS_OFS_IRQ_STATUS)
			irq_status_nxt = 4'h0;
		irq_status_nxt = irq_status_nxt | {(|fall), ev_alt, ev_timeout, ev_done};
	end

	integer k;
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			mod_reset_r   <= `PXS_RST_RESET_CTRL;
			tio_cfg_r     <= `PXS_RST_TIO_CONFIG;
			irq_mask_r    <= `PXS_RST_IRQ_MASK;
			irq_status_r  <= 4'h0;
			reg_rdata_out <= 16'h0000;
			for (k = 0; k < 5; k = k + 1)
				route_r[k] <= `PXS_RST_ROUTE;
		end
		else
		begin
			irq_status_r <= irq_status_nxt;
			if (reg_write_in)
			begin
				case (reg_addr_in)
					`PXS_OFS_RESET_CTRL: mod_reset_r   <= reg_wdata_in[`PXS_BIT_MOD_RESET];
					`PXS_OFS_IRQ0_ROUTE: route_r[0]    <= reg_wdata_in[1:0];
					`PXS_OFS_IRQ1_ROUTE: route_r[1]    <= reg_wdata_in[1:0];
					`PXS_OFS_IRQ2_ROUTE: route_r[2]    <= reg_wdata_in[1:0];
					`PXS_OFS_IRQ3_ROUTE: route_r[3]    <= reg_wdata_in[1:0];
					`PXS_OFS_NMI_ROUTE:  route_r[4]    <= reg_wdata_in[1:0];
					`PXS_OFS_TIO_CONFIG: tio_cfg_r     <= reg_wdata_in[2:0];
					`PXS_OFS_IRQ_MASK:   irq_mask_r    <= reg_wdata_in[3:0];
					default:             mod_reset_r   <= mod_reset_r;
				endcase
			end
			if (reg_read_in)
			begin
				case (reg_addr_in)
					`PXS_OFS_RESET_CTRL: reg_rdata_out <= {15'h0000, mod_reset_r};
					`PXS_OFS_IRQ0_ROUTE: reg_rdata_out <= {14'h0000, route_r[0]};
					`PXS_OFS_IRQ1_ROUTE: reg_rdata_out <= {14'h0000, route_r[1]};
					`PXS_OFS_IRQ2_ROUTE: reg_rdata_out <= {14'h0000, route_r[2]};
					`PXS_OFS_IRQ3_ROUTE: reg_rdata_out <= {14'h0000, route_r[3]};
					`PXS_OFS_NMI_ROUTE:  reg_rdata_out <= {14'h0000, route_r[4]};
					`PXS_OFS_TIO_CONFIG: reg_rdata_out <= {12'h000, timer_io_pin0_in, tio_cfg_r};
					`PXS_OFS_IRQ_STATUS: reg_rdata_out <= {12'h000, irq_status_r};
					`PXS_OFS_IRQ_MASK:   reg_rdata_out <= {12'h000, irq_mask_r};
					`PXS_OFS_BUS_STATUS: reg_rdata_out <= {11'h000, irq_level_n, rdy_sync_r,
					                                       state_r};
					default:             reg_rdata_out <= 16'h0000;
				endcase
			end
		end
	end

endmodule // pxs_site_port

// ===== verif/pxs_site_port_monitor.sv
// Checker for the parallel expansion site port, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps

module pxs_site_port_monitor
#(
	parameter READY_LIMIT = 8
)
(
	input wire        core_clk_in,
	input wire        rst_in,
	input wire        dsp_io_req_in,
	input wire        dsp_io_write_in,
	input wire        space_select_flag_in,
	input wire        dsp_io_ready_out,
	input wire        dsp_io_done_out,
	input wire [15:0] expansion_address_lines_out,
	input wire [15:0] expansion_data_lines_out,
	input wire        expansion_data_oe_out,
	input wire        expansion_strobe_n_out,
	input wire        expansion_write_enable_n_out,
	input wire        expansion_module_reset_n_out,
	input wire        alt_area_req_out,
	input wire [3:0]  dsp_ext_irq_inputs_out,
	input wire        dsp_nmi_out,
	input wire        dsp_timer_out_in,
	input wire        timer_io_pin0_out,
	input wire        timer_io_pin0_oe_out,
	input wire [3:0]  reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire        reg_write_in
);
	wire take = dsp_io_req_in && dsp_io_ready_out;
	wire exp_take = take && !space_select_flag_in;
	wire pulse = |{dsp_nmi_out, dsp_ext_irq_inputs_out};
	reg  tio_gpio_r;

	// Tracks the pin mode so the timer path can be checked.
	always @(posedge core_clk_in)
		if (rst_in)
			tio_gpio_r <= 1'b0;
		else if (reg_write_in && reg_addr_in == 4'h6)
			tio_gpio_r <= reg_wdata_in[0];

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	chk_exp_route: assert property (exp_take |=>
		!expansion_strobe_n_out && !alt_area_req_out) else $error("site not strobed");
	chk_alt_route: assert property (take && space_select_flag_in |->
		##[1:2] alt_area_req_out) else $error("alt area not used");
	chk_site_apart: assert property (alt_area_req_out |->
		expansion_strobe_n_out) else $error("strobe during alt access");
	chk_write_level: assert property (exp_take |=>
		expansion_write_enable_n_out == !$past(dsp_io_write_in)) else $error("bad direction");
	chk_we_strobed: assert property (!expansion_write_enable_n_out |->
		!expansion_strobe_n_out) else $error("write enable without strobe");
	chk_bus_hold: assert property (!expansion_strobe_n_out && !$past(expansion_strobe_n_out) |->
		$stable(expansion_address_lines_out) && $stable(expansion_data_lines_out))
		else $error("bus moved in transfer");
	chk_data_drive: assert property (!expansion_strobe_n_out |->
		expansion_data_oe_out == !expansion_write_enable_n_out) else $error("bad data drive");
	chk_end_done: assert property ($rose(expansion_strobe_n_out) |->
		dsp_io_done_out) else $error("strobe end without done");
	chk_sync_delay: assert property (exp_take |=>
		!dsp_io_done_out [*2]) else $error("ready not synchronised");
	chk_reset_out: assert property (reg_write_in && reg_addr_in == 4'h0 |=>
		expansion_module_reset_n_out == !$past(reg_wdata_in[0])) else $error("bad module reset");
	chk_irq_pulse: assert property (pulse |=> !pulse) else $error("irq not a pulse");
	chk_timer_follow: assert property (!tio_gpio_r && !$past(tio_gpio_r) && !$past(rst_in) |->
		timer_io_pin0_oe_out && timer_io_pin0_out == $past(dsp_timer_out_in))
		else $error("timer not on pin");

	cov_write: cover property (exp_take && dsp_io_write_in ##[3:30] dsp_io_done_out);
	cov_alt: cover property (take && space_select_flag_in);
	cov_irq: cover property (pulse);
endmodule // pxs_site_port_monitor

bind pxs_site_port pxs_site_port_monitor #(.READY_LIMIT(READY_LIMIT)) u_mon
(
	.core_clk_in, .rst_in, .dsp_io_req_in, .dsp_io_write_in, .space_select_flag_in,
	.dsp_io_ready_out, .dsp_io_done_out, .expansion_address_lines_out,
	.expansion_data_lines_out, .expansion_data_oe_out, .expansion_strobe_n_out,
	.expansion_write_enable_n_out, .expansion_module_reset_n_out, .alt_area_req_out,
	.dsp_ext_irq_inputs_out, .dsp_nmi_out, .dsp_timer_out_in, .timer_io_pin0_out,
	.timer_io_pin0_oe_out, .reg_addr_in, .reg_wdata_in, .reg_write_in
);

// ===== verif/pxs_module_model.sv
// Model of the daughter module: sixteen words of storage and ready after
// a programmable wait. Assumes the site's strobe and write enable.
`timescale 1ns/1ps

module pxs_module_model
(
	input  wire        clk_in,
	input  wire        strobe_n_in,
	input  wire        write_n_in,
	input  wire [15:0] addr_in,
	input  wire [15:0] data_in,
	input  wire [4:0]  delay_in,
	output reg         ready_n_out = 1'b1,
	output reg  [15:0] data_out = 16'h0000
);
	reg [15:0] mem [0:15];
	reg [4:0]  cnt_r = 5'h00;

	// Data lines change every cycle until ready is given for a transfer.
	always @(posedge clk_in)
	begin
		if (strobe_n_in || cnt_r < delay_in)
		begin
			ready_n_out <= 1'b1;
			data_out <= ~data_out;
			cnt_r <= strobe_n_in ? 5'h00 : cnt_r + 5'h01;
		end
		else
		begin
			ready_n_out <= 1'b0;
			if (!write_n_in)
				mem[addr_in[3:0]] <= data_in;
			else
				data_out <= mem[addr_in[3:0]];
		end
	end
endmodule // pxs_module_model

// ===== verif/testbench.sv
// Self-checking bench for the parallel expansion site port.
// Assumes the design and the module model compiled before it.
`timescale 1ns/1ps

module testbench;
	logic        core_clk_in = 1'b0, rst_in = 1'b1, dsp_io_req_in = 1'b0;
	logic        dsp_io_write_in = 1'b0, space_select_flag_in = 1'b0;
	logic [15:0] dsp_io_addr_in = 16'h0000, dsp_io_wdata_in = 16'h0000;
	logic [15:0] reg_wdata_in = 16'h0000, rd_v;
	logic        reg_write_in = 1'b0, reg_read_in = 1'b0, pin_ext = 1'b1;
	logic        alt_area_done_in = 1'b0, dsp_timer_out_in = 1'b0, irq_clr = 1'b0;
	logic [7:0]  alt_area_rdata_in = 8'h00, alt_wbyte = 8'h00;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [4:0]  delay = 5'h00, irq_seen = 5'h00;
	logic [1:0]  irq_n = 2'h3;
	logic [15:0] adr [4] = '{16'h0000, 16'hFFFF, 16'h0003, 16'h8004};
	logic [15:0] dat [4] = '{16'hA55A, 16'h0001, 16'hFFFF, 16'h8000};
	wire         dsp_io_ready_out, dsp_io_done_out, expansion_data_oe_out, irq_out;
	wire         expansion_strobe_n_out, expansion_write_enable_n_out, dsp_nmi_out;
	wire         expansion_module_reset_n_out, alt_area_req_out, alt_area_write_out;
	wire         timer_io_pin0_out, timer_io_pin0_oe_out, expansion_ready_n_in;
	wire [15:0]  dsp_io_rdata_out, expansion_address_lines_out, expansion_data_lines_out;
	wire [15:0]  alt_area_addr_out, reg_rdata_out, expansion_data_lines_in;
	wire [7:0]   alt_area_wdata_out;
	wire [3:0]   dsp_ext_irq_inputs_out;
	wire         timer_io_pin0_in = timer_io_pin0_oe_out ? timer_io_pin0_out : pin_ext;
	int          err_total = 0, n_checks = 0, a, d, i;

	pxs_site_port #(.READY_LIMIT(16)) DUT
	(
		.core_clk_in, .rst_in, .dsp_io_req_in, .dsp_io_write_in, .dsp_io_addr_in,
		.dsp_io_wdata_in, .space_select_flag_in, .dsp_io_ready_out, .dsp_io_done_out,
		.dsp_io_rdata_out, .expansion_address_lines_out, .expansion_data_lines_out,
		.expansion_data_oe_out, .expansion_data_lines_in, .expansion_strobe_n_out,
		.expansion_write_enable_n_out, .expansion_ready_n_in, .expansion_module_reset_n_out,
		.expansion_irq0_n_in(irq_n[0]), .expansion_irq1_n_in(irq_n[1]), .alt_area_req_out,
		.alt_area_write_out, .alt_area_addr_out, .alt_area_wdata_out, .alt_area_done_in,
		.alt_area_rdata_in, .dsp_ext_irq_inputs_out, .dsp_nmi_out, .dsp_timer_out_in,
		.timer_io_pin0_in, .timer_io_pin0_out, .timer_io_pin0_oe_out, .reg_addr_in,
		.reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .irq_out
	);

	pxs_module_model MODEL
	(
		.clk_in(core_clk_in), .strobe_n_in(expansion_strobe_n_out),
		.write_n_in(expansion_write_enable_n_out), .addr_in(expansion_address_lines_out),
		.data_in(expansion_data_lines_out), .delay_in(delay),
		.ready_n_out(expansion_ready_n_in), .data_out(expansion_data_lines_in)
	);

	always #2 core_clk_in = ~core_clk_in;

	// Answers the serial site area and gathers routed interrupt pulses.
	always @(posedge core_clk_in)
	begin
		dsp_timer_out_in <= ~dsp_timer_out_in;
		alt_area_done_in <= alt_area_req_out && !alt_area_done_in;
		alt_area_rdata_in <= alt_area_addr_out[7:0] ^ 8'hA5;
		if (alt_area_req_out && alt_area_write_out)
			alt_wbyte <= alt_area_wdata_out;
		irq_seen <= irq_clr ? 5'h00 : irq_seen | {dsp_nmi_out, dsp_ext_irq_inputs_out};
	end

	task automatic chk(input string nm, input logic [15:0] s, e);
	begin
		n_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	end
	endtask

	task automatic wr(input logic [3:0] ad, input logic [15:0] dv);
	begin
		@(posedge core_clk_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= ad;
		reg_wdata_in <= dv;
		@(posedge core_clk_in);
		reg_write_in <= 1'b0;
	end
	endtask

	task automatic rd(input logic [3:0] ad);
	begin
		@(posedge core_clk_in);
		reg_read_in <= 1'b1;
		reg_addr_in <= ad;
		@(posedge core_clk_in);
		reg_read_in <= 1'b0;
		#1 rd_v = reg_rdata_out;
	end
	endtask

	task automatic io(input logic w, f, input logic [15:0] ad, dv, e);
		int n;
	begin
		n = 0;
		@(posedge core_clk_in);
		#1;
		while (dsp_io_ready_out !== 1'b1 && n < 50)
		begin
			@(posedge core_clk_in);
			#1 n++;
		end
		@(posedge core_clk_in);
		dsp_io_req_in <= 1'b1;
		dsp_io_write_in <= w;
		space_select_flag_in <= f;
		dsp_io_addr_in <= ad;
		dsp_io_wdata_in <= dv;
		@(posedge core_clk_in);
		dsp_io_req_in <= 1'b0;
		#1 n = 0;
		while (dsp_io_done_out !== 1'b1 && n < 50)
		begin
			@(posedge core_clk_in);
			#1 n++;
		end
		chk("io_done", {15'h0000, dsp_io_done_out}, 16'h0001);
		if (!w)
			chk("io_rdata", dsp_io_rdata_out, e);
	end
	endtask

	task automatic irq_wait(input logic clr);
	begin
		irq_clr <= clr;
		@(posedge core_clk_in);
		irq_clr <= 1'b0;
		repeat (8) @(posedge core_clk_in);
	end
	endtask

	task automatic stop_test;
	begin
		$display("Checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask

	// Tests need about 400 cycles; fifty times that means a hang.
	initial
	begin
		repeat (20000) @(posedge core_clk_in);
		err_total++;
		stop_test;
	end

	initial
	begin
		repeat (5) @(posedge core_clk_in);
		rst_in <= 1'b0;
		for (a = 0; a < 16; a++)
			if (a != 6 && a != 9)
			begin
				rd(a[3:0]);
				chk("reg_reset", rd_v, 16'h0000);
			end
		wr(4'hF, 16'hFFFF);
		rd(4'hF);
		chk("unmapped", rd_v, 16'h0000);
		wr(4'h0, 16'h0001);
		#1 chk("mod_reset", {15'h0000, expansion_module_reset_n_out}, 16'h0000);
		rd(4'h0);
		chk("reset_ctrl", rd_v, 16'h0001);
		wr(4'h0, 16'h0000);
		#1 chk("mod_run", {15'h0000, expansion_module_reset_n_out}, 16'h0001);
		$display("Test registers done");
		for (i = 0; i < 4; i++)
		begin
			delay <= 5'(i * 3);
			io(1'b1, 1'b0, adr[i], dat[i], 16'h0000);
		end
		for (i = 3; i >= 0; i--)
			io(1'b0, 1'b0, adr[i], 16'h0000, dat[i]);
		io(1'b1, 1'b1, 16'h0012, 16'h773C, 16'h0000);
		chk("alt_wbyte", {8'h00, alt_wbyte}, 16'h003C);
		io(1'b0, 1'b1, 16'h0012, 16'h0000, 16'h00B7);
		rd(4'h7);
		delay <= 5'h1F;
		io(1'b0, 1'b0, 16'h0005, 16'h0000, 16'hFFFF);
		rd(4'h7);
		chk("timeout_status", rd_v, 16'h0002);
		delay <= 5'h00;
		$display("Test transfers done");
		for (d = 0; d < 5; d++)
		begin
			for (a = 1; a < 6; a++)
				wr(a[3:0], (a == d + 1) ? {15'h0000, d[0]} : 16'h0003);
			irq_n[d[0]] <= 1'b0;
			irq_wait(1'b1);
			chk("irq_route", {11'h000, irq_seen}, 16'h0001 << d);
			irq_wait(1'b1);
			chk("irq_level", {11'h000, irq_seen}, 16'h0000);
			irq_n <= 2'h3;
		end
		wr(4'h8, 16'h0008);
		rd(4'h7);
		@(posedge core_clk_in);
		irq_n[0] <= 1'b0;
		irq_wait(1'b0);
		#1 chk("irq_out", {15'h0000, irq_out}, 16'h0001);
		rd(4'h7);
		chk("irq_status", rd_v & 16'h0008, 16'h0008);
		chk("irq_clear", {15'h0000, irq_out}, 16'h0000);
		wr(4'h8, 16'h0000);
		irq_n <= 2'h1;
		irq_wait(1'b0);
		#1 chk("irq_masked", {15'h0000, irq_out}, 16'h0000);
		rd(4'h7);
		chk("irq_masked_status", rd_v & 16'h0008, 16'h0008);
		$display("Test interrupts done");
		wr(4'h6, 16'h0007);
		repeat (2) @(posedge core_clk_in);
		#1 chk("pin_out", {14'h0000, timer_io_pin0_oe_out, timer_io_pin0_out}, 16'h0003);
		wr(4'h6, 16'h0001);
		repeat (4) @(posedge core_clk_in);
		rd(4'h6);
		chk("pin_in", rd_v, 16'h0009);
		chk("pin_oe", {15'h0000, timer_io_pin0_oe_out}, 16'h0000);
		wr(4'h6, 16'h0000);
		repeat (6) @(posedge core_clk_in);
		rd(4'h9);
		chk("bus_status", rd_v, 16'h000C);
		$display("Test timer pin done");
		stop_test;
	end
endmodule // testbench
